// ### design/swl_pkg.sv
package swl_pkg;
    // Clock rate used to turn microseconds into cycles
    localparam int CLK_MHZ = 100;
    localparam int TIMER_W = 16;
    localparam int BYTE_BITS = 8;

    // Reset classification times, as printed
    localparam int RST_LONG_US = 480;
    localparam int OD_KEEP_US = 80;
    localparam int RST_DET_STD_US = 120;
    localparam int RST_DET_OD_US = 16;

    // Slot and presence timing; plain defaults, tune per process
    localparam int SAMPLE_STD_US = 30;
    localparam int SAMPLE_OD_US = 3;
    localparam int HOLD_STD_US = 30;
    localparam int HOLD_OD_US = 3;
    localparam int PDH_STD_US = 30;
    localparam int PDH_OD_US = 3;
    localparam int PDL_STD_US = 120;
    localparam int PDL_OD_US = 12;
    localparam int REH_STD_US = 5;
    localparam int REH_OD_US = 1;
    localparam int FILT_STD_US = 1;

    // Derived cycle counts (whole microseconds give exact counts)
    localparam int RST_LONG_CYC = RST_LONG_US * CLK_MHZ;
    localparam int OD_KEEP_CYC = OD_KEEP_US * CLK_MHZ;
    localparam int RST_DET_STD_CYC = RST_DET_STD_US * CLK_MHZ;
    localparam int RST_DET_OD_CYC = RST_DET_OD_US * CLK_MHZ;
    localparam int SAMPLE_STD_CYC = SAMPLE_STD_US * CLK_MHZ;
    localparam int SAMPLE_OD_CYC = SAMPLE_OD_US * CLK_MHZ;
    localparam int HOLD_STD_CYC = HOLD_STD_US * CLK_MHZ;
    localparam int HOLD_OD_CYC = HOLD_OD_US * CLK_MHZ;
    localparam int PDH_STD_CYC = PDH_STD_US * CLK_MHZ;
    localparam int PDH_OD_CYC = PDH_OD_US * CLK_MHZ;
    localparam int PDL_STD_CYC = PDL_STD_US * CLK_MHZ;
    localparam int PDL_OD_CYC = PDL_OD_US * CLK_MHZ;
    localparam int REH_STD_CYC = REH_STD_US * CLK_MHZ;
    localparam int REH_OD_CYC = REH_OD_US * CLK_MHZ;
    localparam int FILT_STD_CYC = FILT_STD_US * CLK_MHZ;

    // Network command codes seen by this block
    localparam logic [7:0] CMD_OD_SKIP = 8'h3c;
    localparam logic [7:0] CMD_COND_READ = 8'h0f;

    typedef enum logic [2:0] {
        SWL_IDLE = 3'b000,
        SWL_LOW = 3'b001,
        SWL_PDH = 3'b010,
        SWL_PDL = 3'b011,
        SWL_HOLD = 3'b100
    } swl_state_t;

    typedef enum logic [1:0] {
        SWL_CH_OFF = 2'b00,
        SWL_CH_ON = 2'b01,
        SWL_CH_DONE = 2'b10
    } swl_chain_t;
endpackage

// ### design/swl_slave.sv
`timescale 1ns/10ps
// Operation
// - Standard timing by default; fast flag selects fast timing for every waveform.
// - Master makes all falling edges; device only starts the presence pulse itself.
// - Reset low of 480us or more clears fast speed.
// - In fast speed, reset low up to 80us keeps fast speed.
// - Fast-speed reset between 80us and 480us resets; standard speed afterwards.
// - After reset rise, wait presence delay, then drive low presence time.
// - Each time slot carries exactly one bit, write or read.
// - Falling below low threshold starts slot timer for sampling and read hold.
// - Read zero: device pulls low until its timer expires; read one: never drives.
// - Extra falling-edge low-pass filter at standard speed only.
// - Dips staying above threshold minus hysteresis are no falling edge.
// - Lows inside the rising hold-off window are ignored; later ones start slots.
// - First chain enable is held low; each done output feeds next enable.
// - Armed device answers identity read only while its enable input is low.
// - Line low past 120us standard or 16us fast resets the device.
// - Fast-skip command 3Ch sets the fast flag until a reset low longer than 80us.
// - Done command (ignored while chain is off) drives done output low and stops further identity answers.
module swl_slave #(
    parameter int TIMER_W = swl_pkg::TIMER_W,
    parameter int RST_LONG_CYC = swl_pkg::RST_LONG_CYC,
    parameter int OD_KEEP_CYC = swl_pkg::OD_KEEP_CYC,
    parameter int RST_DET_STD_CYC = swl_pkg::RST_DET_STD_CYC,
    parameter int RST_DET_OD_CYC = swl_pkg::RST_DET_OD_CYC,
    parameter int SAMPLE_STD_CYC = swl_pkg::SAMPLE_STD_CYC,
    parameter int SAMPLE_OD_CYC = swl_pkg::SAMPLE_OD_CYC,
    parameter int HOLD_STD_CYC = swl_pkg::HOLD_STD_CYC,
    parameter int HOLD_OD_CYC = swl_pkg::HOLD_OD_CYC,
    parameter int PDH_STD_CYC = swl_pkg::PDH_STD_CYC,
    parameter int PDH_OD_CYC = swl_pkg::PDH_OD_CYC,
    parameter int PDL_STD_CYC = swl_pkg::PDL_STD_CYC,
    parameter int PDL_OD_CYC = swl_pkg::PDL_OD_CYC,
    parameter int REH_STD_CYC = swl_pkg::REH_STD_CYC,
    parameter int REH_OD_CYC = swl_pkg::REH_OD_CYC,
    parameter int FILT_STD_CYC = swl_pkg::FILT_STD_CYC
) (
    input wire logic clk_i,                          // 100 MHz clock
    input wire logic arst_n_i,                       // Async reset, active low
    input wire logic en_i,                           // Clock enable, freezes all state
    input wire logic line_above_th_i,                // Line above high threshold
    input wire logic line_below_tl_i,                // Line below low threshold
    output logic line_o,                             // Pin output level, always low
    output logic line_oe_o,                          // Pin pulldown enable
    input wire logic tx_en_i,                        // Next slot is a read slot
    input wire logic tx_bit_i,                       // Bit to return in that slot
    output logic rx_bit_o,                           // Level sampled in last slot
    output logic rx_valid_o,                         // Pulse: one bit per slot
    output logic [7:0] cmd_byte_o,                   // First byte after reset
    output logic cmd_valid_o,                        // Pulse: first byte complete
    output logic bus_reset_o,                        // Pulse: reset pulse ended
    output logic fast_speed_flag_o,                  // Fast timing in force
    input wire logic chain_on_i,                     // Pulse: arm chain
    input wire logic chain_done_i,                   // Pulse: chain done
    input wire logic chain_off_i,                    // Pulse: chain off
    input wire logic sequence_enable_input_n_i,      // Chain enable, active low
    output logic sequence_done_output_n_o,           // Chain done, active low
    output logic id_answer_o                         // Send identity in this transaction
);
    // Long reset count must fit the slot timer and exceed the keep count; refused while elaborating
    if (RST_LONG_CYC >= (2 ** TIMER_W) - 1 || TIMER_W > 31 || OD_KEEP_CYC >= RST_LONG_CYC) begin : g_bad_cfg
        $error("swl_slave: timer too narrow or reset limits inconsistent");
    end

    typedef struct packed {
        swl_pkg::swl_state_t st;
        logic [TIMER_W-1:0] timer;
        logic [TIMER_W-1:0] filt;
        logic fast;
        logic drive;
        logic sampled;
        logic is_rst;
        logic rx_bit;
        logic rx_valid;
        logic [7:0] shift;
        logic [3:0] bitcnt;
        logic cmd_done;
        logic [7:0] cmd_byte;
        logic cmd_valid;
        logic bus_reset;
        swl_pkg::swl_chain_t chain;
        logic done_n;
        logic answer;
    } swl_regs_t;

    localparam swl_regs_t RESET_REGS = '{
        st: swl_pkg::SWL_IDLE, timer: '0, filt: '0, fast: 1'b0, drive: 1'b0,
        sampled: 1'b0, is_rst: 1'b0, rx_bit: 1'b0, rx_valid: 1'b0, shift: 8'h00,
        bitcnt: 4'h0, cmd_done: 1'b0, cmd_byte: 8'h00, cmd_valid: 1'b0,
        bus_reset: 1'b0, chain: swl_pkg::SWL_CH_OFF, done_n: 1'b1, answer: 1'b0
    };

    swl_regs_t q;
    swl_regs_t next_q;

    // Pick the count for the current speed
    function automatic logic [TIMER_W-1:0] pick(input logic fast, input int std_c, input int od_c);
        pick = fast ? TIMER_W'(od_c) : TIMER_W'(std_c);
    endfunction

    always_comb begin
        next_q = q;
        next_q.rx_valid = 1'b0;
        next_q.cmd_valid = 1'b0;
        next_q.bus_reset = 1'b0;
        case (q.st)
            // Wait for the master's falling edge below the low threshold
            swl_pkg::SWL_IDLE: begin
                if (line_below_tl_i) begin
                    if (q.filt != {TIMER_W{1'b1}}) begin
                        next_q.filt = q.filt + 1'b1;
                    end
                    // Fast speed bypasses the low-pass delay
                    if (q.fast || q.filt + 1'b1 >= TIMER_W'(FILT_STD_CYC)) begin
                        next_q.st = swl_pkg::SWL_LOW;
                        next_q.timer = '0;
                        next_q.sampled = 1'b0;
                        next_q.is_rst = 1'b0;
                        // Pull only when the master already holds the line low
                        next_q.drive = tx_en_i && !tx_bit_i;
                    end
                end else begin
                    next_q.filt = '0;
                end
            end
            // Slot timer runs from the recognised falling edge
            swl_pkg::SWL_LOW: begin
                if (q.timer != {TIMER_W{1'b1}}) begin
                    next_q.timer = q.timer + 1'b1;
                end
                if (q.drive && q.timer >= pick(q.fast, HOLD_STD_CYC, HOLD_OD_CYC)) begin
                    next_q.drive = 1'b0;
                end
                if (!q.sampled && q.timer >= pick(q.fast, SAMPLE_STD_CYC, SAMPLE_OD_CYC)) begin
                    next_q.sampled = 1'b1;
                    next_q.rx_bit = line_above_th_i;
                    next_q.rx_valid = 1'b1;
                    // Gather the command byte, least significant bit first
                    if (!q.cmd_done) begin
                        next_q.shift = {line_above_th_i, q.shift[7:1]};
                        next_q.bitcnt = q.bitcnt + 4'h1;
                        if (q.bitcnt == 4'(swl_pkg::BYTE_BITS - 1)) begin
                            next_q.cmd_done = 1'b1;
                            next_q.cmd_valid = 1'b1;
                            next_q.cmd_byte = {line_above_th_i, q.shift[7:1]};
                            if ({line_above_th_i, q.shift[7:1]} == swl_pkg::CMD_OD_SKIP) begin
                                next_q.fast = 1'b1;
                            end
                            next_q.answer = q.chain == swl_pkg::SWL_CH_ON
                                && !sequence_enable_input_n_i
                                && {line_above_th_i, q.shift[7:1]} == swl_pkg::CMD_COND_READ;
                        end
                    end
                end
                if (q.timer >= pick(q.fast, RST_DET_STD_CYC, RST_DET_OD_CYC)) begin
                    next_q.is_rst = 1'b1;
                    next_q.drive = 1'b0;
                end
                if (line_above_th_i && !q.drive) begin
                    if (q.is_rst) begin
                        // Speed after reset follows the low length
                        if (q.timer >= TIMER_W'(RST_LONG_CYC)) begin
                            next_q.fast = 1'b0;
                        end else if (!(q.fast && q.timer <= TIMER_W'(OD_KEEP_CYC))) begin
                            next_q.fast = 1'b0;
                        end
                        next_q.st = swl_pkg::SWL_PDH;
                        next_q.timer = '0;
                        next_q.bus_reset = 1'b1;
                        next_q.cmd_done = 1'b0;
                        next_q.bitcnt = 4'h0;
                        next_q.answer = 1'b0;
                    end else if (q.sampled) begin
                        next_q.st = swl_pkg::SWL_HOLD;
                        next_q.timer = '0;
                    end
                end
            end
            // Presence delay after the reset rise
            swl_pkg::SWL_PDH: begin
                next_q.timer = q.timer + 1'b1;
                if (q.timer >= pick(q.fast, PDH_STD_CYC, PDH_OD_CYC)) begin
                    next_q.st = swl_pkg::SWL_PDL;
                    next_q.timer = '0;
                    next_q.drive = 1'b1;
                end
            end
            // Presence low, then wait for the line to come back high
            swl_pkg::SWL_PDL: begin
                if (q.drive) begin
                    next_q.timer = q.timer + 1'b1;
                    if (q.timer >= pick(q.fast, PDL_STD_CYC, PDL_OD_CYC)) begin
                        next_q.drive = 1'b0;
                    end
                end else if (line_above_th_i) begin
                    next_q.st = swl_pkg::SWL_HOLD;
                    next_q.timer = '0;
                end
            end
            // Hold-off: lows of any depth are ignored here
            swl_pkg::SWL_HOLD: begin
                next_q.timer = q.timer + 1'b1;
                if (q.timer >= pick(q.fast, REH_STD_CYC, REH_OD_CYC)) begin
                    next_q.st = swl_pkg::SWL_IDLE;
                    next_q.filt = '0;
                end
            end
            default: begin
                next_q.st = swl_pkg::SWL_IDLE;
                next_q.drive = 1'b0;
            end
        endcase

        // Chain state; off beats done, and done (ignored while off) beats on, when pulses coincide
        if (chain_off_i) begin
            next_q.chain = swl_pkg::SWL_CH_OFF;
        end else if (chain_done_i && q.chain != swl_pkg::SWL_CH_OFF) begin
            next_q.chain = swl_pkg::SWL_CH_DONE;
        end else if (chain_on_i) begin
            next_q.chain = swl_pkg::SWL_CH_ON;
        end
        // Done output passes the turn on to the next device
        next_q.done_n = next_q.chain != swl_pkg::SWL_CH_DONE;
        if (next_q.chain != swl_pkg::SWL_CH_ON) begin
            next_q.answer = 1'b0;
        end
    end

    // Single state register; clock enable freezes everything
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= RESET_REGS;
        end else if (en_i) begin
            q <= next_q;
        end
    end

    // Outputs straight from the state register; pin level is a constant low
    assign line_o = 1'b0;
    assign line_oe_o = q.drive;
    assign rx_bit_o = q.rx_bit;
    assign rx_valid_o = q.rx_valid;
    assign cmd_byte_o = q.cmd_byte;
    assign cmd_valid_o = q.cmd_valid;
    assign bus_reset_o = q.bus_reset;
    assign fast_speed_flag_o = q.fast;
    assign sequence_done_output_n_o = q.done_n;
    assign id_answer_o = q.answer;
endmodule

// ### sim/swl_master_model.sv
`timescale 1ns/10ps
// Master side of the wire: open drain with pull-up, wired with the device pulldown
module swl_master_model (
    input wire logic pull_low_i, // Master pulls the line low
    input wire logic shallow_i, // Dip that stays above the low threshold
    input wire logic dev_oe_i, // Device pulldown enable
    output logic above_th_o, // Line above high threshold
    output logic below_tl_o // Line below low threshold
);
    // Wired-AND: any pulldown wins, a shallow dip only clears the high comparator
    assign below_tl_o = pull_low_i | dev_oe_i;
    assign above_th_o = !below_tl_o && !shallow_i;
endmodule

// ### sim/swl_checker.sv
`timescale 1ns/10ps
// Speed, presence and chain relations seen at the slave's pins
module swl_checker #(
    parameter int RST_LONG_CYC = swl_pkg::RST_LONG_CYC,
    parameter int OD_KEEP_CYC = swl_pkg::OD_KEEP_CYC,
    parameter int PDH_STD_CYC = swl_pkg::PDH_STD_CYC,
    parameter int PDH_OD_CYC = swl_pkg::PDH_OD_CYC,
    parameter int PDL_STD_CYC = swl_pkg::PDL_STD_CYC,
    parameter int PDL_OD_CYC = swl_pkg::PDL_OD_CYC
) (
    input wire logic clk_i, // Clock
    input wire logic arst_n_i, // Async reset
    input wire logic line_below_tl_i, // Line low
    input wire logic line_o, // Pin level
    input wire logic line_oe_o, // Pulldown
    input wire logic [7:0] cmd_byte_o, // First byte
    input wire logic cmd_valid_o, // Byte pulse
    input wire logic bus_reset_o, // Reset end
    input wire logic fast_speed_flag_o, // Fast timing
    input wire logic chain_done_i, // Done pulse
    input wire logic chain_off_i, // Off pulse
    input wire logic sequence_enable_input_n_i, // Chain enable
    input wire logic sequence_done_output_n_o, // Chain done
    input wire logic id_answer_o // Identity answer
);
    localparam int DS_LO = PDH_STD_CYC - 2;
    localparam int DS_HI = PDH_STD_CYC + 4;
    localparam int DF_LO = PDH_OD_CYC - 2;
    localparam int DF_HI = PDH_OD_CYC + 4;
    localparam int LS = PDL_STD_CYC + 1;
    localparam int LF = PDL_OD_CYC + 1;
    logic [15:0] low_run;
    logic below_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // Length of the latest low, held after the rise so a reset end can be judged
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            low_run <= 16'h0;
            below_q <= 1'b0;
        end else begin
            below_q <= line_below_tl_i;
            if (line_below_tl_i) begin
                low_run <= below_q ? low_run + 16'h1 : 16'h1;
            end
        end
    end
    property p_open_drain; line_o == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin level not low");
    property p_pres_std; bus_reset_o ##1 !fast_speed_flag_o |->
        ##[DS_LO:DS_HI] $rose(line_oe_o) ##LS $fell(line_oe_o); endproperty
    a_pres_std: assert property (p_pres_std) else $error("standard presence");
    property p_pres_fast; bus_reset_o ##1 fast_speed_flag_o |->
        ##[DF_LO:DF_HI] $rose(line_oe_o) ##LF $fell(line_oe_o); endproperty
    a_pres_fast: assert property (p_pres_fast) else $error("fast presence");
    property p_long_reset; bus_reset_o && low_run >= RST_LONG_CYC + 2 |-> ##2 !fast_speed_flag_o;
    endproperty
    a_long_reset: assert property (p_long_reset) else $error("fast kept on long reset");
    property p_short_reset;
        bus_reset_o && fast_speed_flag_o && low_run + 16'h2 < OD_KEEP_CYC |-> ##2 fast_speed_flag_o;
    endproperty
    a_short_reset: assert property (p_short_reset) else $error("fast lost on short reset");
    property p_fast_cmd; cmd_valid_o && cmd_byte_o == swl_pkg::CMD_OD_SKIP |->
        ##[0:1] fast_speed_flag_o; endproperty
    a_fast_cmd: assert property (p_fast_cmd) else $error("fast not set");
    property p_answer; $rose(id_answer_o) |->
        cmd_byte_o == swl_pkg::CMD_COND_READ && !$past(sequence_enable_input_n_i); endproperty
    a_answer: assert property (p_answer) else $error("identity answer cause");
    property p_done; $fell(sequence_done_output_n_o) |-> $past(chain_done_i); endproperty
    a_done: assert property (p_done) else $error("done without command");
    property p_off; chain_off_i |=> sequence_done_output_n_o; endproperty
    a_off: assert property (p_off) else $error("done kept after off");
endmodule
bind swl_slave swl_checker #(.RST_LONG_CYC(RST_LONG_CYC), .OD_KEEP_CYC(OD_KEEP_CYC),
    .PDH_STD_CYC(PDH_STD_CYC), .PDH_OD_CYC(PDH_OD_CYC), .PDL_STD_CYC(PDL_STD_CYC),
    .PDL_OD_CYC(PDL_OD_CYC)) i_swl_checker (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .line_below_tl_i(line_below_tl_i), .line_o(line_o), .line_oe_o(line_oe_o),
    .cmd_byte_o(cmd_byte_o), .cmd_valid_o(cmd_valid_o), .bus_reset_o(bus_reset_o),
    .fast_speed_flag_o(fast_speed_flag_o), .chain_done_i(chain_done_i),
    .chain_off_i(chain_off_i), .sequence_enable_input_n_i(sequence_enable_input_n_i),
    .sequence_done_output_n_o(sequence_done_output_n_o), .id_answer_o(id_answer_o));

// ### sim/tb.sv
`timescale 1ns/10ps
module tb;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic pull_low = 1'b0;
    logic shallow = 1'b0;
    logic tx_en_i = 1'b0;
    logic tx_bit_i = 1'b0;
    logic chain_on_i = 1'b0;
    logic chain_done_i = 1'b0;
    logic chain_off_i = 1'b0;
    logic sequence_enable_input_n_i = 1'b1;
    logic en = 1'b1;
    // Short counts keep the run small; one cycle stands for one microsecond
    localparam int T_RST_LONG = 480;
    localparam int T_OD_KEEP = 80;
    localparam int T_DET_STD = 120;
    localparam int T_DET_OD = 16;
    localparam int T_SMP_STD = 30;
    localparam int T_SMP_OD = 3;
    localparam int T_HOLD_STD = 30;
    localparam int T_HOLD_OD = 3;
    localparam int T_PDH_STD = 30;
    localparam int T_PDH_OD = 3;
    localparam int T_PDL_STD = 120;
    localparam int T_PDL_OD = 12;
    localparam int T_REH_STD = 5;
    localparam int T_REH_OD = 1;
    localparam int T_FILT = 2;
    logic line_above_th_i, line_below_tl_i, line_o, line_oe_o, rx_bit_o, rx_valid_o;
    logic cmd_valid_o, bus_reset_o, fast_speed_flag_o, sequence_done_output_n_o, id_answer_o;
    logic [7:0] cmd_byte_o;
    logic fs = 1'b0;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int n_rx = 0;
    int n;
    swl_master_model i_swl_master_model (.pull_low_i(pull_low), .shallow_i(shallow),
        .dev_oe_i(line_oe_o), .above_th_o(line_above_th_i), .below_tl_o(line_below_tl_i));
    // Short counts keep the run small; presence lengths below follow from them
    swl_slave #(.RST_LONG_CYC(T_RST_LONG), .OD_KEEP_CYC(T_OD_KEEP), .RST_DET_STD_CYC(T_DET_STD),
        .RST_DET_OD_CYC(T_DET_OD), .SAMPLE_STD_CYC(T_SMP_STD), .SAMPLE_OD_CYC(T_SMP_OD),
        .HOLD_STD_CYC(T_HOLD_STD), .HOLD_OD_CYC(T_HOLD_OD), .PDH_STD_CYC(T_PDH_STD),
        .PDH_OD_CYC(T_PDH_OD), .PDL_STD_CYC(T_PDL_STD), .PDL_OD_CYC(T_PDL_OD),
        .REH_STD_CYC(T_REH_STD), .REH_OD_CYC(T_REH_OD), .FILT_STD_CYC(T_FILT)) i_swl_slave (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i), .en_i(en), .line_above_th_i(line_above_th_i),
        .line_below_tl_i(line_below_tl_i), .line_o(line_o), .line_oe_o(line_oe_o),
        .tx_en_i(tx_en_i), .tx_bit_i(tx_bit_i), .rx_bit_o(rx_bit_o), .rx_valid_o(rx_valid_o),
        .cmd_byte_o(cmd_byte_o), .cmd_valid_o(cmd_valid_o), .bus_reset_o(bus_reset_o),
        .fast_speed_flag_o(fast_speed_flag_o), .chain_on_i(chain_on_i),
        .chain_done_i(chain_done_i), .chain_off_i(chain_off_i),
        .sequence_enable_input_n_i(sequence_enable_input_n_i),
        .sequence_done_output_n_o(sequence_done_output_n_o), .id_answer_o(id_answer_o));
    always #5 clk_i = ~clk_i;
    // Slot counter and hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (rx_valid_o === 1'b1) n_rx++;
        if (cyc == 40000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    // Middle-length fast resets were settled as standard speed
    function automatic logic exp_fast(input logic f, input int low);
        return f && low <= 80;
    endfunction
    task automatic bus_rst(input int low);
        int d;
        fs = exp_fast(fs, low);
        pull_low <= 1'b1;
        wt(low);
        pull_low <= 1'b0;
        d = 0;
        while (line_oe_o !== 1'b1 && d < 300) begin
            wt(1);
            d++;
        end
        wt(2);
        chk(line_below_tl_i, 1'b1, "no presence");
        chk(fast_speed_flag_o, fs, "speed after reset");
        d = 2;
        while (line_oe_o === 1'b1 && d < 300) begin
            wt(1);
            d++;
        end
        chk(16'(d), fs ? 16'd13 : 16'd121, "presence length");
        wt(fs ? 48 : 480);
    endtask
    // Write-one and read slots use the short low, write-zero the long one
    task automatic slot(input logic b, input logic rd);
        tx_en_i <= rd;
        tx_bit_i <= b;
        pull_low <= 1'b1;
        wt((b || rd) ? (fs ? 1 : 4) : (fs ? 6 : 45));
        pull_low <= 1'b0;
        wt(fs ? 2 : 12);
        if (rd) chk(line_above_th_i, b, "read bit");
        wt(fs ? 8 : 40);
        chk(rx_bit_o, b, "sampled bit");
    endtask
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 8; i++) slot(b[i], 1'b0);
        chk(cmd_byte_o, b, "command byte");
    endtask
    initial begin
        void'($urandom(32'h5615));
        wt(10);
        arst_n_i <= 1'b1;
        wt(3);
        // Standard speed: random reset lengths and first bytes, then reads
        repeat (3) begin
            bus_rst(130 + int'($urandom() % 200));
            send(8'($urandom()) & 8'hfe);
        end
        slot(1'b0, 1'b1);
        slot(1'b1, 1'b1);
        $display("test standard done");
        // A shallow dip and a one-cycle low must not open a slot
        n = n_rx;
        shallow <= 1'b1;
        wt(20);
        shallow <= 1'b0;
        pull_low <= 1'b1;
        wt(1);
        pull_low <= 1'b0;
        wt(20);
        // A low while the clock enable is off must leave no trace
        en <= 1'b0;
        pull_low <= 1'b1;
        wt(6);
        pull_low <= 1'b0;
        wt(1);
        en <= 1'b1;
        wt(10);
        chk(16'(n_rx - n), 16'h0, "glitch seen as slot");
        $display("test glitch done");
        // Fast speed entered, kept over a short reset, dropped by longer ones
        bus_rst(140);
        send(8'h3c);
        chk(fast_speed_flag_o, 1'b1, "fast not set");
        fs = 1'b1;
        bus_rst(20);
        send(8'($urandom()));
        slot(1'b0, 1'b1);
        slot(1'b1, 1'b1);
        bus_rst(200);
        send(8'h3c);
        fs = 1'b1;
        bus_rst(500);
        $display("test speed done");
        // Chain: answer only while enabled, silent after done
        chain_on_i <= 1'b1;
        wt(1);
        chain_on_i <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            if (k == 2) chain_done_i <= 1'b1;
            sequence_enable_input_n_i <= (k == 1);
            wt(1);
            chain_done_i <= 1'b0;
            bus_rst(140);
            send(8'h0f);
            chk(id_answer_o, k == 0, "identity answer");
        end
        chk(sequence_done_output_n_o, 1'b0, "done output");
        chain_off_i <= 1'b1;
        wt(1);
        chain_off_i <= 1'b0;
        wt(2);
        chk(sequence_done_output_n_o, 1'b1, "done kept");
        $display("test chain done");
        final_report();
    end
endmodule
